//--- core/fpg_pkg.sv
// Package: register map, field layout and types of the four pin port
`default_nettype none
package fpg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int PINS = 4;
	localparam logic [7:0] PIN_CTRL_ADDR = 8'h3C;
	localparam int TIMER_OUT_ENABLE_EN_BIT = 15;
	localparam int DIR_LSB = 8;
	localparam int VAL_LSB = 0;
	localparam int TIMER_PIN = 3;
	localparam int BRANCH_PIN = 2;
	localparam logic [15:0] PIN_CTRL_RESET = 16'h0000;
	localparam logic [15:0] PIN_CTRL_WMASK = 16'h8F0F;
	localparam int TIMER_W = 16;
	localparam int PRESCALE_W = 4;
	localparam logic [15:0] TIMER_PERIOD_RESET = 16'hFFFF;
	localparam logic [3:0] PRESCALE_RESET = 4'hF;

	typedef struct packed {
		logic timer_out_enable_en;
		logic [PINS-1:0] dir;
		logic [PINS-1:0] val;
	} fpg_ctrl_t;

	typedef struct packed {
		logic [PINS-1:0] o;
		logic [PINS-1:0] oe_n;
	} fpg_pad_t;
endpackage : fpg_pkg
`default_nettype wire

//--- core/fpg_timer.sv
// Down-counting timer with prescaler that feeds the pin mux
`default_nettype none
module fpg_timer #(
	parameter int CNT_W = fpg_pkg::TIMER_W,
	parameter int PRE_W = fpg_pkg::PRESCALE_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [CNT_W-1:0] period,
	input wire logic [PRE_W-1:0] prescale,
	output logic tick,
	output logic pulse_q
);
	logic [CNT_W-1:0] cnt_q;
	logic [PRE_W-1:0] pre_q;
	wire pre_zero = (pre_q == '0);
	wire cnt_zero = (cnt_q == '0);

	if (CNT_W < 1 || PRE_W < 1) begin : g_bad_width
		$error("fpg_timer: widths must be positive");
	end

	always_ff @(posedge sys_clk) begin
		// Nonzero reload at reset keeps the interrupt low
		if (!rst_n) begin
			cnt_q <= CNT_W'(fpg_pkg::TIMER_PERIOD_RESET);
			pre_q <= PRE_W'(fpg_pkg::PRESCALE_RESET);
			pulse_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= period;
			pre_q <= prescale;
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= pre_zero && cnt_zero;
			if (pre_zero) begin
				pre_q <= prescale;
				cnt_q <= cnt_zero ? period : cnt_q - 1'b1;
			end else begin
				pre_q <= pre_q - 1'b1;
			end
		end
	end

	assign tick = run && pre_zero && cnt_zero;
endmodule : fpg_timer
`default_nettype wire

//--- core/fpg_port.sv
// Four pin general-purpose port with timer override on pin 3
`default_nettype none
// Notes on behaviour
// - One control register at 0x3C, four pins
// - Timer enable drives pin 3, readable
// - Enable clear: pin 3 ordinary
// - Bits 14-12 and 7-4 reserved
// - Direction bit: 0 input, 1 output
// - Value bits drive outputs, read inputs
// - Pin 2 input feeds branch condition
// - Timer on pin 3 only host mode
// - Timer: 16-bit down-counter, 4-bit prescaler
module fpg_port #(
	parameter int PINS = fpg_pkg::PINS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [fpg_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [fpg_pkg::DATA_W-1:0] mem_wdata,
	output logic [fpg_pkg::DATA_W-1:0] mem_rdata,
	input wire logic [PINS-1:0] gp_pin_n_i,
	output logic [PINS-1:0] gp_pin_n_o,
	output logic [PINS-1:0] gp_pin_n_oe_n,
	input wire logic external_interface_select,
	input wire logic timer_run,
	input wire logic [fpg_pkg::TIMER_W-1:0] timer_period,
	input wire logic [fpg_pkg::PRESCALE_W-1:0] timer_prescale,
	output logic timer_irq,
	output logic branch_input_condition
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (PINS != fpg_pkg::PINS) begin : g_bad_pins
		$error("fpg_port: pin count is fixed at four");
	end
	if (fpg_pkg::TIMER_PIN >= PINS) begin : g_bad_timer_pin
		$error("fpg_port: timer pin lies outside the port");
	end
	if (fpg_pkg::BRANCH_PIN >= PINS) begin : g_bad_branch_pin
		$error("fpg_port: branch pin lies outside the port");
	end
	if (fpg_pkg::VAL_LSB + PINS > fpg_pkg::DIR_LSB) begin : g_bad_val_field
		$error("fpg_port: value field overlaps direction field");
	end
	if (fpg_pkg::DIR_LSB + PINS > fpg_pkg::TIMER_OUT_ENABLE_EN_BIT) begin : g_bad_dir_field
		$error("fpg_port: direction field overlaps timer enable");
	end
	if (fpg_pkg::TIMER_OUT_ENABLE_EN_BIT >= fpg_pkg::DATA_W) begin : g_bad_enable_bit
		$error("fpg_port: timer enable outside the data word");
	end

	// ----------------------------------------
	// Decoding functions
	// ----------------------------------------
	// Register select, shared by write and read
	function automatic logic is_ctrl_addr(input logic [fpg_pkg::ADDR_W-1:0] addr);
		return addr == fpg_pkg::PIN_CTRL_ADDR;
	endfunction : is_ctrl_addr

	function automatic fpg_pkg::fpg_ctrl_t unpack_ctrl(
		input logic [fpg_pkg::DATA_W-1:0] word
	);
		fpg_pkg::fpg_ctrl_t c;
		logic [fpg_pkg::DATA_W-1:0] kept;
		kept = word & fpg_pkg::PIN_CTRL_WMASK;
		c.timer_out_enable_en = kept[fpg_pkg::TIMER_OUT_ENABLE_EN_BIT];
		c.dir = kept[fpg_pkg::DIR_LSB +: PINS];
		c.val = kept[fpg_pkg::VAL_LSB +: PINS];
		return c;
	endfunction : unpack_ctrl

	function automatic logic [fpg_pkg::DATA_W-1:0] pack_read(
		input fpg_pkg::fpg_ctrl_t c,
		input logic [PINS-1:0] levels
	);
		logic [fpg_pkg::DATA_W-1:0] w;
		w = '0;
		w[fpg_pkg::TIMER_OUT_ENABLE_EN_BIT] = c.timer_out_enable_en;
		w[fpg_pkg::DIR_LSB +: PINS] = c.dir;
		w[fpg_pkg::VAL_LSB +: PINS] = levels;
		return w;
	endfunction : pack_read

	// ----------------------------------------
	// Pin and mode synchronisers
	// ----------------------------------------
	logic [PINS-1:0] pin_s1_q;
	logic [PINS-1:0] pin_s2_q;
	logic xsel_s1_q;
	logic xsel_s2_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			xsel_s1_q <= 1'b1;
			xsel_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= gp_pin_n_i;
			pin_s2_q <= pin_s1_q;
			xsel_s1_q <= external_interface_select;
			xsel_s2_q <= xsel_s1_q;
		end
	end

	// ----------------------------------------
	// Timer
	// ----------------------------------------
	logic timer_level;

	fpg_timer #(
		.CNT_W(fpg_pkg::TIMER_W),
		.PRE_W(fpg_pkg::PRESCALE_W)
	) u_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(timer_run),
		.period(timer_period),
		.prescale(timer_prescale),
		.tick(timer_irq),
		.pulse_q(timer_level)
	);

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	fpg_pkg::fpg_ctrl_t ctrl_q;
	fpg_pkg::fpg_ctrl_t ctrl_d;

	wire hit = is_ctrl_addr(mem_addr);
	wire wr_en = hit && mem_wr;
	wire rd_en = hit && mem_rd;

	assign ctrl_d = unpack_ctrl(mem_wdata);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_q <= '0;
		end else if (wr_en) begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------
	// Pin mux
	// ----------------------------------------
	// host mode gate
	wire timer_on_pin = ctrl_q.timer_out_enable_en && !xsel_s2_q;
	logic [PINS-1:0] drive;
	logic [PINS-1:0] level;
	logic [PINS-1:0] seen;

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			if (g == fpg_pkg::TIMER_PIN) begin : g_tmr
				assign drive[g] = timer_on_pin || (!ctrl_q.timer_out_enable_en && ctrl_q.dir[g]);
				assign level[g] = timer_on_pin ? timer_level : ctrl_q.val[g];
				assign seen[g] = ctrl_q.timer_out_enable_en ? timer_level
					: (ctrl_q.dir[g] ? ctrl_q.val[g] : pin_s2_q[g]);
			end else begin : g_gp
				assign drive[g] = ctrl_q.dir[g];
				assign level[g] = ctrl_q.val[g];
				assign seen[g] = ctrl_q.dir[g] ? ctrl_q.val[g] : pin_s2_q[g];
			end
		end
	endgenerate

	fpg_pkg::fpg_pad_t pad_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pad_q.o <= '0;
			pad_q.oe_n <= '1;
		end else begin
			pad_q.o <= level;
			pad_q.oe_n <= ~drive;
		end
	end

	assign gp_pin_n_o = pad_q.o;
	assign gp_pin_n_oe_n = pad_q.oe_n;

	logic branch_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			branch_q <= 1'b0;
		end else begin
			branch_q <= ctrl_q.dir[fpg_pkg::BRANCH_PIN] ? 1'b0 : pin_s2_q[fpg_pkg::BRANCH_PIN];
		end
	end
	assign branch_input_condition = branch_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [fpg_pkg::DATA_W-1:0] rd_word;
	logic [fpg_pkg::DATA_W-1:0] rdata_q;

	assign rd_word = pack_read(ctrl_q, seen);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (rd_en) begin
			rdata_q <= rd_word;
		end else begin
			rdata_q <= '0;
		end
	end
	assign mem_rdata = rdata_q;
endmodule : fpg_port
`default_nettype wire

//--- test/fpg_port_asserts.sv
// Checker for the four pin port
`default_nettype none
module fpg_port_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic [3:0] gp_pin_n_o,
	input wire logic [3:0] gp_pin_n_oe_n,
	input wire logic external_interface_select,
	input wire logic timer_irq,
	input wire logic branch_input_condition
);
	timeunit 1ns;
	timeprecision 1ps;
	wire hit = mem_addr == 8'h3C;
	logic [15:0] wd_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) wd_q <= 16'h0000;
		else if (mem_wr && hit) wd_q <= mem_wdata;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence wr_s(t); mem_wr && hit && mem_wdata[15] == t ##1 !mem_wr; endsequence
	sequence xis_s(v); (external_interface_select == v) [*4]; endsequence
	rd_other_a: assert property (mem_rd && !hit |=> mem_rdata == 16'h0000)
		else $error("off map read not zero");
	rd_back_a: assert property (mem_rd && hit && !mem_wr
		|=> mem_rdata[15:4] == {wd_q[15], 3'h0, wd_q[11:8], 4'h0}) else $error("bad read");
	dir_out_a: assert property (wr_s(0) |=> gp_pin_n_oe_n == ~wd_q[11:8])
		else $error("direction mismatch");
	val_out_a: assert property (wr_s(0)
		|=> (gp_pin_n_o & wd_q[11:8]) == (wd_q[3:0] & wd_q[11:8])) else $error("bad level");
	timer_out_enable_off_a: assert property (xis_s(1) ##0 wr_s(1) |=> gp_pin_n_oe_n[3])
		else $error("pin 3 driven off host mode");
	timer_out_enable_on_a: assert property (xis_s(0) ##0 wr_s(1) |=> !gp_pin_n_oe_n[3])
		else $error("timer not on pin 3");
	bio_gate_a: assert property (!gp_pin_n_oe_n[2] [*2] |-> !branch_input_condition)
		else $error("branch from output pin");
	irq_pulse_a: assert property ($rose(timer_irq) |=> !timer_irq) else $error("irq long");
endmodule : fpg_port_asserts
bind fpg_port fpg_port_asserts i_chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.mem_addr(mem_addr),
	.mem_wr(mem_wr),
	.mem_rd(mem_rd),
	.mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata),
	.gp_pin_n_o(gp_pin_n_o),
	.gp_pin_n_oe_n(gp_pin_n_oe_n),
	.external_interface_select(external_interface_select),
	.timer_irq(timer_irq),
	.branch_input_condition(branch_input_condition)
);
`default_nettype wire

//--- test/fpg_board.sv
// Board side of the four general-purpose pins
`default_nettype none
module fpg_board (
	input wire logic [3:0] gp_pin_n_o,
	input wire logic [3:0] gp_pin_n_oe_n,
	input wire logic [3:0] drv,
	output logic [3:0] gp_pin_n_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Board drives only released pins
	assign gp_pin_n_i = (gp_pin_n_o & ~gp_pin_n_oe_n) | (drv & gp_pin_n_oe_n);
endmodule : fpg_board
`default_nettype wire

//--- test/fpg_port_test.sv
// Self-checking bench for the four pin port
`default_nettype none
module fpg_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rst_n = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
	logic external_interface_select = 1'b1, timer_run = 1'b0, timer_irq, branch_input_condition;
	logic [7:0] mem_addr = 8'h00;
	logic [15:0] mem_wdata = 16'h0000, timer_period = 16'h0003, mem_rdata;
	logic [3:0] timer_prescale = 4'h1, drv = 4'h0, gp_pin_n_i, gp_pin_n_o, gp_pin_n_oe_n;
	int n_mismatch = 0, n_compared = 0, seen = 0, nirq = 0;
	always #10 sys_clk = ~sys_clk;
	fpg_port i_dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.mem_addr(mem_addr),
		.mem_wr(mem_wr),
		.mem_rd(mem_rd),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata),
		.gp_pin_n_i(gp_pin_n_i),
		.gp_pin_n_o(gp_pin_n_o),
		.gp_pin_n_oe_n(gp_pin_n_oe_n),
		.external_interface_select(external_interface_select),
		.timer_run(timer_run),
		.timer_period(timer_period),
		.timer_prescale(timer_prescale),
		.timer_irq(timer_irq),
		.branch_input_condition(branch_input_condition)
	);
	fpg_board i_board (
		.gp_pin_n_o(gp_pin_n_o),
		.gp_pin_n_oe_n(gp_pin_n_oe_n),
		.drv(drv),
		.gp_pin_n_i(gp_pin_n_i)
	);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		n_mismatch += int'(got !== exp);
		if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
	endtask : chk
	// Called on a rising edge; returns on a rising edge
	task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		mem_wr <= w;
		mem_rd <= !w;
		mem_addr <= a;
		mem_wdata <= d;
		@(posedge sys_clk);
		mem_wr <= 1'b0;
		mem_rd <= 1'b0;
		#1;
		if (!w) chk(mem_rdata, d);
		@(posedge sys_clk);
	endtask : acc
	task pins(input logic [8:0] e);
		repeat (4) @(posedge sys_clk);
		#1;
		chk({7'h00, branch_input_condition, gp_pin_n_oe_n, gp_pin_n_i}, {7'h00, e});
		@(posedge sys_clk);
	endtask : pins
	task complete_run;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (2000) @(posedge sys_clk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		acc(1'b0, 8'h3C, 16'h0000);
		pins(9'h0F0);
		acc(1'b1, 8'h3C, 16'h7FF5);
		acc(1'b0, 8'h3C, 16'h0F05);
		pins(9'h005);
		acc(1'b1, 8'h3D, 16'h0000);
		acc(1'b0, 8'h3C, 16'h0F05);
		acc(1'b0, 8'h3D, 16'h0000);
		$display("register test done");
		acc(1'b1, 8'h3C, 16'h0000);
		drv <= 4'hA;
		pins(9'h0FA);
		acc(1'b0, 8'h3C, 16'h000A);
		drv <= 4'h5;
		pins(9'h1F5);
		acc(1'b1, 8'h3C, 16'h0404);
		pins(9'h0B5);
		$display("pin test done");
		acc(1'b1, 8'h3C, 16'h8000);
		pins(9'h1F5);
		external_interface_select <= 1'b0;
		timer_run <= 1'b1;
		repeat (4) @(posedge sys_clk);
		acc(1'b1, 8'h3C, 16'h8000);
		repeat (40) @(posedge sys_clk) begin
			seen = seen | gp_pin_n_i[3];
			nirq = nirq + timer_irq;
		end
		chk({12'h000, gp_pin_n_oe_n}, 16'h0007);
		chk({15'h0000, seen > 0}, 16'h0001);
		chk({15'h0000, nirq > 0}, 16'h0001);
		external_interface_select <= 1'b1;
		pins(9'h1F5);
		$display("timer test done");
		// Mid-run reset must clear the timer enable and data bits
		drv <= 4'h0;
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		acc(1'b0, 8'h3C, 16'h0000);
		pins(9'h0F0);
		$display("reset test done");
		complete_run();
	end
endmodule : fpg_port_test
`default_nettype wire
